// [bench/chipset_model.sv]
`timescale 1ns/1ps
module chipset_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // line write-back handshake
  input wire logic writeback_line_req,
  input wire logic slow,
  output logic writeback_done
);
  logic [3:0] wait_cnt;
  logic busy;

  // every write-back started is finished, never dropped
  // slow answers stretch the flush so ordering bugs show up
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      writeback_done <= 1'b0;
    end else begin
      writeback_done <= 1'b0;
      if (writeback_line_req) begin
        busy <= 1'b1;
        wait_cnt <= slow ? 4'h6 : 4'h0;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        writeback_done <= 1'b1;
      end
    end
  end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
`include "bus_mode_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("FAIL %0t got %0h exp %0h", $time, g, e); end end
`define WAIT_HI(s, lim) n = 0; \
  while ((s) !== 1'b1 && n < (lim)) begin \
    @(posedge aclk); \
    #1; \
    n++; \
  end
module tb_top;
  import bus_mode_pkg::*;
  logic aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic line_policy_select, burst_length_select, ext_write_buffer_empty;
  logic snoop_kill_line, line_alloc, snoop_addr_strobe, bus_hold_ack;
  logic address_hold_request, bus_backoff, cache_purge_req;
  logic writeback_invalidate_instr, writeback_done, soft_restart_pin;
  logic instr_boundary, core_lock_n, code_fetch_req, fetch_page_ok;
  logic fetch_data_valid, fetch_data_used, data_req, data_region_ok;
  logic exec_req, exec_past_limit, enhanced_mode, mode_valid;
  flush_state_e flush_state;
  logic cache_invalidate, writeback_line_req, flush_ack_cycle;
  logic burst_len_eff, write_buffer_empty_eff, kill_line_eff;
  logic line_writeback, line_state_valid, snoop_accept, pseudo_lock_out;
  logic warm_restart_pending, warm_restart_take, code_fetch_issue;
  logic data_cycle_issue, opcode_discard, exec_ok, gp_fault, slow;
  int fail_count, samples_checked, wb_cnt, ack_cnt, n;

  bus_mode_init_prefetch_ctrl dut (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .line_policy_select,
    .burst_length_select, .ext_write_buffer_empty, .snoop_kill_line,
    .line_alloc, .snoop_addr_strobe, .bus_hold_ack, .address_hold_request,
    .bus_backoff, .cache_purge_req, .writeback_invalidate_instr,
    .writeback_done, .soft_restart_pin, .instr_boundary, .core_lock_n,
    .code_fetch_req, .fetch_page_ok, .fetch_data_valid, .fetch_data_used,
    .data_req, .data_region_ok, .exec_req, .exec_past_limit, .enhanced_mode,
    .mode_valid, .flush_state, .cache_invalidate, .writeback_line_req,
    .flush_ack_cycle, .burst_len_eff, .write_buffer_empty_eff, .kill_line_eff,
    .line_writeback, .line_state_valid, .snoop_accept, .pseudo_lock_out,
    .warm_restart_pending, .warm_restart_take, .code_fetch_issue,
    .data_cycle_issue, .opcode_discard, .exec_ok, .gp_fault
  );

  chipset_model far_end (
    .aclk, .aresetn, .writeback_line_req, .slow, .writeback_done
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // pulses are counted here so none slip past a polling loop
  always @(posedge aclk) begin
    if (writeback_line_req === 1'b1)
      wb_cnt <= wb_cnt + 1;
    if (flush_ack_cycle === 1'b1)
      ack_cnt <= ack_cnt + 1;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= {28'h0, a};
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= {28'h0, a};
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // strap flips after capture so a resampling design is caught
  task automatic do_reset(input logic s);
    @(posedge aclk);
    aresetn <= 1'b0;
    line_policy_select <= s;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    line_policy_select <= ~s;
  endtask

  // expect: accept, burst, buffer empty, kill, line write-back, lock
  task automatic wb_case(input logic [2:0] h, input logic [5:0] e);
    @(posedge aclk);
    {bus_hold_ack, address_hold_request, bus_backoff} <= h;
    {snoop_addr_strobe, burst_length_select, snoop_kill_line} <= 3'b111;
    {line_alloc, line_policy_select} <= 2'b11;
    {ext_write_buffer_empty, core_lock_n} <= 2'b00;
    @(posedge aclk);
    {bus_hold_ack, address_hold_request, bus_backoff} <= 3'b000;
    {snoop_addr_strobe, burst_length_select, snoop_kill_line} <= 3'b000;
    {line_alloc, line_policy_select} <= 2'b00;
    {ext_write_buffer_empty, core_lock_n} <= 2'b11;
    #1;
    `CHK({snoop_accept, burst_len_eff, write_buffer_empty_eff,
          kill_line_eff, line_writeback, pseudo_lock_out}, e)
    `CHK(line_state_valid, 1'b1)
  endtask

  initial begin
    {awaddr, wdata, araddr, awprot, arprot} = '0;
    {awvalid, wvalid, bready, arvalid, rready, aresetn, slow} = '0;
    {line_policy_select, burst_length_select, snoop_kill_line} = '0;
    {line_alloc, snoop_addr_strobe, bus_hold_ack, address_hold_request} = '0;
    {bus_backoff, cache_purge_req, writeback_invalidate_instr} = '0;
    {soft_restart_pin, instr_boundary, code_fetch_req, fetch_page_ok} = '0;
    {fetch_data_valid, fetch_data_used, data_req, data_region_ok} = '0;
    {exec_req, exec_past_limit, fail_count, samples_checked} = '0;
    {wb_cnt, ack_cnt, n} = '0;
    {wstrb, ext_write_buffer_empty, core_lock_n} = 6'h3F;
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      axi_rd(`ADDR_STATUS);
      `CHK(d, {30'h0, 1'b1, m[0]})
      `CHK(enhanced_mode, m[0])
      @(posedge aclk);
      soft_restart_pin <= 1'b1;
      `WAIT_HI(warm_restart_pending, 5)
      `CHK(warm_restart_pending, 1'b1)
      @(posedge aclk);
      instr_boundary <= 1'b1;
      `WAIT_HI(warm_restart_take, 5)
      `CHK(warm_restart_take, 1'b1)
      @(posedge aclk);
      instr_boundary <= 1'b0;
      // restart input still high: bus cycles must keep flowing
      for (int k = 0; k < 2; k++) begin
        @(posedge aclk);
        {code_fetch_req, data_req, exec_req, fetch_data_valid} <= 4'hF;
        {fetch_page_ok, data_region_ok, fetch_data_used} <= {3{k[0]}};
        exec_past_limit <= ~k[0];
        @(posedge aclk);
        {code_fetch_req, data_req, exec_req, fetch_data_valid} <= 4'h0;
        #1;
        `CHK({code_fetch_issue, data_cycle_issue}, {2{k[0]}})
        `CHK({exec_ok, gp_fault}, {k[0], ~k[0]})
        `CHK(opcode_discard, ~k[0])
      end
      @(posedge aclk);
      soft_restart_pin <= 1'b0;
      `CHK(enhanced_mode, m[0])
      if (m == 0) begin
        wb_case(3'b000, 6'b101000);
        @(posedge aclk);
        cache_purge_req <= 1'b1;
        @(posedge aclk);
        cache_purge_req <= 1'b0;
        #1;
        {wb_cnt, ack_cnt} = '0;
        `WAIT_HI(cache_invalidate, 30)
        `CHK(n >= 15 && n <= 20, 1'b1)
        `WAIT_HI(flush_ack_cycle, 40)
        `CHK(wb_cnt + ack_cnt, 0)
      end else begin
        wb_case(3'b000, 6'b010011);
        for (int k = 0; k < 3; k++)
          wb_case(3'b100 >> k, 6'b110111);
        axi_rd(`ADDR_DIRTY);
        `CHK({r, d}, {`RESP_OKAY, 32'h0})
        axi_rd(4'hC);
        `CHK({r, d}, {`RESP_SLVERR, 32'h0})
        axi_wr(4'hC, 32'h1);
        `CHK(r, `RESP_SLVERR)
        axi_wr(`ADDR_DIRTY, 32'h3);
        `CHK(r, `RESP_OKAY)
        axi_rd(`ADDR_DIRTY);
        `CHK({r, d}, {`RESP_OKAY, 32'h3})
        axi_rd(`ADDR_CTRL);
        `CHK(d, 32'h0)
        // instruction, purge pin, then register trigger
        for (int k = 0; k < 3; k++) begin
          #1;
          {wb_cnt, ack_cnt} = '0;
          if (k == 2) begin
            axi_wr(`ADDR_CTRL, 32'h1);
          end else begin
            @(posedge aclk);
            slow <= k[0];
            {writeback_invalidate_instr, cache_purge_req} <= {~k[0], k[0]};
            @(posedge aclk);
            {writeback_invalidate_instr, cache_purge_req} <= 2'b00;
          end
          `WAIT_HI(flush_ack_cycle, 300)
          `CHK(cache_invalidate, 1'b1)
          // the counters catch a pulse one edge after it is launched
          @(posedge aclk);
          #1;
          `CHK(wb_cnt, 3)
          `CHK(ack_cnt, 1)
          `CHK(flush_state, F_IDLE)
        end
        axi_wr(`ADDR_STATUS, 32'hF);
        `CHK(r, `RESP_OKAY)
      end
      axi_rd(`ADDR_STATUS);
      `CHK(d, {28'h0, 3'b001, m[0]})
    end
    end_sim;
  end

  initial begin
    repeat (6000) @(posedge aclk);
    fail_count++;
    end_sim;
  end
endmodule

// [hdl/bus_mode_init_prefetch_ctrl.sv]
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "bus_mode_defs.svh"
module bus_mode_init_prefetch_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // mode strap and write-back inputs
  input wire logic line_policy_select,
  input wire logic burst_length_select,
  input wire logic ext_write_buffer_empty,
  input wire logic snoop_kill_line,
  input wire logic line_alloc,
  // snoop
  input wire logic snoop_addr_strobe,
  input wire logic bus_hold_ack,
  input wire logic address_hold_request,
  input wire logic bus_backoff,
  // cache purge
  input wire logic cache_purge_req,
  input wire logic writeback_invalidate_instr,
  input wire logic writeback_done,
  // warm restart
  input wire logic soft_restart_pin,
  input wire logic instr_boundary,
  // core fetch and execution requests
  input wire logic core_lock_n,
  input wire logic code_fetch_req,
  input wire logic fetch_page_ok,
  input wire logic fetch_data_valid,
  input wire logic fetch_data_used,
  input wire logic data_req,
  input wire logic data_region_ok,
  input wire logic exec_req,
  input wire logic exec_past_limit,
  // mode and flush results
  output logic enhanced_mode,
  output logic mode_valid,
  output bus_mode_pkg::flush_state_e flush_state,
  output logic cache_invalidate,
  output logic writeback_line_req,
  output logic flush_ack_cycle,
  // write-back controls as used
  output logic burst_len_eff,
  output logic write_buffer_empty_eff,
  output logic kill_line_eff,
  output logic line_writeback,
  output logic line_state_valid,
  // snoop, lock, restart
  output logic snoop_accept,
  output logic pseudo_lock_out,
  output logic warm_restart_pending,
  output logic warm_restart_take,
  // bus cycle issue
  output logic code_fetch_issue,
  output logic data_cycle_issue,
  output logic opcode_discard,
  output logic exec_ok,
  output logic gp_fault
);
  import bus_mode_pkg::*;

  // register bus
  logic writeback_invalidate_instr_sw;
  line_count_t dirty_lines;
  wire write_hs = awready && awvalid && wready && wvalid;
  wire read_hs = arready && arvalid;
  wire [3:0] wa = awaddr[3:0];
  wire [3:0] ra = araddr[3:0];
  wire w_ctrl = (wa == `ADDR_CTRL);
  wire w_dirty = (wa == `ADDR_DIRTY);
  wire w_hit = w_ctrl || w_dirty || (wa == `ADDR_STATUS);
  wire r_status = (ra == `ADDR_STATUS);
  wire r_dirty = (ra == `ADDR_DIRTY);
  wire r_hit = r_status || r_dirty || (ra == `ADDR_CTRL);
  wire flush_busy = (flush_state != F_IDLE);
  wire [31:0] status_word = {28'h0000000, warm_restart_pending,
                             flush_busy, mode_valid, enhanced_mode};
  wire [31:0] read_word = r_status ? status_word
                        : r_dirty ? {16'h0000, dirty_lines}
                        : 32'h00000000;
  // accept address and data together once both are offered
  wire next_wready = awvalid && wvalid && !awready && !bvalid;
  wire next_arready = arvalid && !arready && !rvalid;
  wire [15:0] next_dirty = {wstrb[1] ? wdata[15:8] : dirty_lines[15:8],
                            wstrb[0] ? wdata[7:0] : dirty_lines[7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
    end else begin
      awready <= next_wready;
      wready <= next_wready;
      arready <= next_arready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (write_hs) begin
      bvalid <= 1'b1;
      bresp <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (read_hs) begin
      rvalid <= 1'b1;
      rdata <= read_word;
      rresp <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // control writes: flush trigger self-clears, dirty count held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      writeback_invalidate_instr_sw <= 1'b0;
      dirty_lines <= `DIRTY_RESET;
    end else begin
      writeback_invalidate_instr_sw <= write_hs && w_ctrl && wstrb[0]
                   && wdata[`CTRL_WRITEBACK_INVALIDATE_INSTR_BIT];
      if (write_hs && w_dirty) begin
        dirty_lines <= next_dirty;
      end
    end
  end

  // mode strap: a floating strap reads low through the pad pulldown,
  // so an unconnected board lands in standard mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_valid <= 1'b0;
      enhanced_mode <= 1'b0;
    end else if (!mode_valid) begin
      // first edge after release; only hard reset reopens it
      mode_valid <= 1'b1;
      enhanced_mode <= line_policy_select;
    end
  end

  wire std_mode = mode_valid && !enhanced_mode;
  wire enh_mode = mode_valid && enhanced_mode;

  // flush sequencing
  flush_state_e next_state;
  logic [4:0] inval_count;
  logic inval_zero;
  line_count_t lines_left;
  logic lines_zero;
  wire flush_start = cache_purge_req || writeback_invalidate_instr
                     || writeback_invalidate_instr_sw;
  wire inval_load = (flush_state == F_IDLE) && std_mode && flush_start;
  wire lines_load = (flush_state == F_IDLE) && enh_mode && flush_start;
  wire lines_dec = (flush_state == F_WBWAIT) && writeback_done;
  wire next_inval_pulse = ((flush_state == F_INVAL) && inval_zero)
                          || (flush_state == F_ACK);
  wire next_wb_req = (flush_state == F_WBREQ) && !lines_zero;
  wire next_ack = (flush_state == F_ACK);

  cycle_timer #(.W(5)) u_inval_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(inval_load),
    .load_value(`PURGE_INVAL_CLKS),
    .dec(flush_state == F_INVAL),
    .count(inval_count),
    .zero(inval_zero)
  );

  cycle_timer #(.W(16)) u_line_count (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(lines_load),
    .load_value(dirty_lines),
    .dec(lines_dec),
    .count(lines_left),
    .zero(lines_zero)
  );

  always_comb begin
    next_state = flush_state;
    case (flush_state)
      F_IDLE: begin
        if (inval_load) begin
          next_state = F_INVAL;
        end else if (lines_load) begin
          next_state = F_WBREQ;
        end
      end
      F_INVAL: begin
        if (inval_zero) begin
          next_state = F_IDLE;
        end
      end
      F_WBREQ: begin
        // acknowledge only once every dirty line is out
        next_state = lines_zero ? F_ACK : F_WBWAIT;
      end
      F_WBWAIT: begin
        if (writeback_done) begin
          next_state = F_WBREQ;
        end
      end
      F_ACK: begin
        next_state = F_IDLE;
      end
      default: begin
        next_state = F_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush_state <= F_IDLE;
      cache_invalidate <= 1'b0;
      writeback_line_req <= 1'b0;
      flush_ack_cycle <= 1'b0;
    end else begin
      flush_state <= next_state;
      cache_invalidate <= next_inval_pulse;
      writeback_line_req <= next_wb_req;
      flush_ack_cycle <= next_ack;
    end
  end

  // write-back inputs; standard mode sees fixed neutral values, except line_alloc still drives line_state_valid
  wire next_snoop = snoop_addr_strobe
                    && (std_mode
                        || (enh_mode && (bus_hold_ack
                            || address_hold_request || bus_backoff)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_len_eff <= 1'b0;
      write_buffer_empty_eff <= 1'b1;
      kill_line_eff <= 1'b0;
      line_writeback <= 1'b0;
      line_state_valid <= 1'b0;
      snoop_accept <= 1'b0;
      pseudo_lock_out <= 1'b1;
    end else begin
      burst_len_eff <= enh_mode && burst_length_select;
      write_buffer_empty_eff <= !enh_mode || ext_write_buffer_empty;
      kill_line_eff <= enh_mode && snoop_kill_line && next_snoop;
      line_writeback <= enh_mode && line_alloc
                        && line_policy_select;
      line_state_valid <= mode_valid && line_alloc;
      snoop_accept <= next_snoop;
      pseudo_lock_out <= enh_mode || core_lock_n;
    end
  end

  // warm restart: edge caught, taken at a boundary; mode untouched
  logic restart_d;
  wire restart_edge = soft_restart_pin && !restart_d;
  wire restart_take = warm_restart_pending && instr_boundary;
  // a new edge in the taking cycle stays pending
  wire next_pending = restart_edge
                      || (warm_restart_pending && !instr_boundary);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_d <= 1'b0;
      warm_restart_pending <= 1'b0;
      warm_restart_take <= 1'b0;
    end else begin
      restart_d <= soft_restart_pin;
      warm_restart_pending <= next_pending;
      warm_restart_take <= restart_take;
    end
  end

  // fetches are never held off by restart or a halt exit, so the far
  // side must finish every cycle it sees
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_fetch_issue <= 1'b0;
      data_cycle_issue <= 1'b0;
      opcode_discard <= 1'b0;
      exec_ok <= 1'b0;
      gp_fault <= 1'b0;
    end else begin
      code_fetch_issue <= code_fetch_req && fetch_page_ok;
      data_cycle_issue <= data_req && data_region_ok;
      opcode_discard <= fetch_data_valid && !fetch_data_used;
      exec_ok <= exec_req && !exec_past_limit;
      gp_fault <= exec_req && exec_past_limit;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence std_purge_seen;
    (flush_state == F_IDLE) && std_mode && flush_start;
  endsequence

  sequence inval_in_window;
    ##[15:20] cache_invalidate;
  endsequence

  // reset sampled high keeps the release edge itself out of the check
  a_mode_capture: assert property (
    aresetn && !mode_valid |=> mode_valid
      && enhanced_mode == $past(line_policy_select))
    else $error("bus mode not captured from strap");

  a_mode_fixed: assert property (
    mode_valid |=> $stable(enhanced_mode) && mode_valid)
    else $error("bus mode changed without hard reset");

  a_restart_keeps_mode: assert property (
    mode_valid && soft_restart_pin |=> $stable(enhanced_mode)[*2])
    else $error("warm restart disturbed bus mode");

  a_std_no_ack: assert property (
    std_mode |-> !flush_ack_cycle && !writeback_line_req)
    else $error("standard mode ran flush ack or write-back");

  a_std_inval_window: assert property (
    std_purge_seen |-> inval_in_window)
    else $error("standard purge invalidate outside 15 to 20 clocks");

  a_ack_after_wb: assert property (
    $rose(flush_ack_cycle) |-> lines_zero && $past(flush_state) == F_ACK)
    else $error("flush ack before write-backs finished");

  a_std_ignore: assert property (
    std_mode |=> !burst_len_eff && write_buffer_empty_eff
                 && !kill_line_eff && !line_writeback)
    else $error("standard mode used a write-back input");

  a_std_snoop: assert property (
    std_mode && snoop_addr_strobe |=> snoop_accept)
    else $error("standard snoop strobe not sampled");

  a_enh_snoop: assert property (
    enh_mode && snoop_addr_strobe && !bus_hold_ack
      && !address_hold_request && !bus_backoff |=> !snoop_accept)
    else $error("enhanced snoop sampled outside hold or backoff");

  a_pseudo_lock_out_high: assert property (
    enh_mode |=> pseudo_lock_out)
    else $error("pseudo lock driven low in enhanced mode");

  a_restart_edge: assert property (
    $rose(soft_restart_pin) |=> warm_restart_pending)
    else $error("warm restart edge not caught");

  a_restart_take: assert property (
    warm_restart_pending && instr_boundary |=> warm_restart_take)
    else $error("warm restart not taken at boundary");

  a_fetch_blocked: assert property (
    code_fetch_req && !fetch_page_ok |=> !code_fetch_issue)
    else $error("code fetch issued to inaccessible page");

  a_limit_fault: assert property (
    exec_req && exec_past_limit |=> gp_fault && !exec_ok)
    else $error("execution past limit without protection fault");

endmodule

// [hdl/cycle_timer.sv]
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic dec,
  // state
  output logic [W-1:0] count,
  output logic zero
);

  assign zero = (count == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (dec && !zero) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// [pkg/bus_mode_defs.svh]
`ifndef BUS_MODE_DEFS_SVH
`define BUS_MODE_DEFS_SVH

// register byte offsets, low four address bits
`define ADDR_STATUS 4'h0
`define ADDR_CTRL 4'h4
`define ADDR_DIRTY 4'h8

// status fields
`define ST_MODE_BIT 0
`define ST_VALID_BIT 1
`define ST_BUSY_BIT 2
`define ST_WARM_BIT 3

// control fields
`define CTRL_WRITEBACK_INVALIDATE_INSTR_BIT 0

// reset values
`define DIRTY_RESET 16'h0000

// purge invalidate window in system clocks
`define PURGE_MIN_CLKS 5'd15
`define PURGE_MAX_CLKS 5'd20
`define PURGE_INVAL_CLKS (`PURGE_MIN_CLKS + 5'd1)

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [pkg/bus_mode_pkg.sv]
package bus_mode_pkg;

  typedef enum logic [4:0] {
    F_IDLE   = 5'b00001,
    F_INVAL  = 5'b00010,
    F_WBREQ  = 5'b00100,
    F_WBWAIT = 5'b01000,
    F_ACK    = 5'b10000
  } flush_state_e;

  typedef logic [15:0] line_count_t;

endpackage
